// ==== dcc_channel.v ====
`include "dcc_consts.vh"
module dcc_channel #(
  // Scales every debounce interval; lower it to shorten simulations
  parameter [31:0] DB_TICKS_PER_US = 32'h00000030
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire clk_en_in,
  input wire chan_in,
  input wire invert_in,
  input wire [1:0] db_mode_in,
  input wire [3:0] db_sel_in,
  input wire [2:0] mode_in,
  input wire wide_in,
  input wire [1:0] per_mult_in,
  input wire [1:0] tb_sel_in,
  input wire [3:0] map_in,
  input wire [1:0] map_sel_in,
  input wire [1:0] map_fn_in,
  input wire scan_start_in,
  input wire sos_in,
  input wire rd_lo_in,
  output wire deb_out,
  output reg [31:0] scan_val_out,
  output reg [31:0] rd_val_out,
  output reg [1:0] slots_out
);
  // Input synchroniser
  reg sync1_q;
  reg sync2_q;
  // Edge history
  reg deb_prev_q;
  reg map_prev_q;
  // 48 MHz tick generation
  reg [7:0] ph_q;
  reg tick48_q;
  // Timebase prescaler
  reg [9:0] pre_q;
  reg tbt_q;
  // Counter and measurement state
  reg [31:0] cnt_q;
  reg [31:0] res_q;
  reg [9:0] ecnt_q;
  reg run_q;
  reg arm_q;

  // Debounced level, active high after inversion
  wire deb_w;
  // Inverter output
  wire inv_w;
  // Selected mapped channel level
  wire map_lvl_w;
  wire own_edge_w;
  wire own_fall_w;
  wire map_edge_w;
  wire gate_ok_w;
  wire up_w;
  wire dec_w;
  wire meas_w;
  wire latch_w;
  wire [31:0] top_w;
  wire [31:0] view_w;
  wire [7:0] ph_sum_w;
  reg [9:0] tb_div_w;
  reg [9:0] per_n_w;
  reg [31:0] cnt_d;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (clk_en_in) begin
      sync1_q <= chan_in;
      sync2_q <= sync1_q;
    end
  end

  assign inv_w = sync2_q ^ invert_in;

  // Filter; its output also feeds the other channels
  dcc_debounce #(
    .TICKS_PER_US(DB_TICKS_PER_US)
  ) u_deb (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .lvl_in(inv_w),
    .tick_in(tick48_q),
    .mode_in(db_mode_in),
    .sel_in(db_sel_in),
    .lvl_out(deb_w)
  );

  assign deb_out = deb_w;

  // phase accumulator for 48 MHz ticks
  // Ticks jitter by one clock; the average rate is exact
  assign ph_sum_w = ph_q + `DCC_SYS_MHZ;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ph_q <= 8'h00;
      tick48_q <= 1'b0;
    end else if (clk_en_in) begin
      if (ph_sum_w >= `DCC_CLK_MHZ) begin
        ph_q <= ph_sum_w - `DCC_CLK_MHZ;
        tick48_q <= 1'b1;
      end else begin
        ph_q <= ph_sum_w;
        tick48_q <= 1'b0;
      end
    end
  end

  // Timebase divider choice
  always @* begin
    case (tb_sel_in)
      2'h0: tb_div_w = `DCC_X1;
      2'h1: tb_div_w = `DCC_X10;
      2'h2: tb_div_w = `DCC_X100;
      default: tb_div_w = `DCC_X1000;
    endcase
  end

  // Period multiplier choice
  always @* begin
    case (per_mult_in)
      2'h0: per_n_w = `DCC_X1;
      2'h1: per_n_w = `DCC_X10;
      2'h2: per_n_w = `DCC_X100;
      default: per_n_w = `DCC_X1000;
    endcase
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      pre_q <= 10'h000;
      tbt_q <= 1'b0;
    end else if (clk_en_in) begin
      tbt_q <= 1'b0;
      if (tick48_q) begin
        if (pre_q >= tb_div_w - `DCC_X1) begin
          pre_q <= 10'h000;
          tbt_q <= 1'b1;
        end else begin
          pre_q <= pre_q + `DCC_X1;
        end
      end
    end
  end

  assign map_lvl_w = map_in[map_sel_in];
  assign own_edge_w = deb_w & ~deb_prev_q;
  assign own_fall_w = ~deb_w & deb_prev_q;
  assign map_edge_w = map_lvl_w & ~map_prev_q;
  assign gate_ok_w = (map_fn_in != `DCC_MAP_GATE) | map_lvl_w;
  assign dec_w = map_edge_w & (map_fn_in == `DCC_MAP_DEC);
  assign latch_w = map_edge_w & (map_fn_in == `DCC_MAP_LATCH);
  assign up_w = own_edge_w & gate_ok_w;
  assign meas_w = (mode_in == `DCC_M_PERIOD) |
                  (mode_in == `DCC_M_PULSE) |
                  (mode_in == `DCC_M_TIMING);
  // width sets the stop-mode saturation top
  assign top_w = wide_in ? `DCC_TOP32 : {16'h0000, `DCC_TOP16};
  // Value offered to scans and reads
  assign view_w = meas_w ? res_q : cnt_q;

  // Narrow results saturate at the 16-bit top
  function [31:0] dcc_clip;
    input [31:0] v;
    input w;
    begin
      if (!w && (v[31:16] != 16'h0000)) begin
        dcc_clip = {16'h0000, `DCC_TOP16};
      end else begin
        dcc_clip = v;
      end
    end
  endfunction

  // Next count in the counting modes
  always @* begin
    cnt_d = cnt_q;
    if (mode_in == `DCC_M_STOP) begin
      if (up_w && (cnt_q < top_w)) begin
        cnt_d = cnt_q + `DCC_ONE32;
      end
    end else if (up_w) begin
      cnt_d = cnt_q + `DCC_ONE32;
    end
    if (dec_w) begin
      cnt_d = cnt_d - `DCC_ONE32;
    end
  end

  // Edge history registers
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      deb_prev_q <= 1'b0;
      map_prev_q <= 1'b0;
    end else if (clk_en_in) begin
      deb_prev_q <= deb_w;
      map_prev_q <= map_lvl_w;
    end
  end

  // Counter, measurements and read snapshots
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= `DCC_ZERO32;
      res_q <= `DCC_ZERO32;
      ecnt_q <= 10'h000;
      run_q <= 1'b0;
      arm_q <= 1'b0;
      scan_val_out <= `DCC_ZERO32;
      rd_val_out <= `DCC_ZERO32;
      slots_out <= `DCC_SLOTS16;
    end else if (clk_en_in) begin
      slots_out <= wide_in ? `DCC_SLOTS32 : `DCC_SLOTS16;
      if (scan_start_in) begin
        cnt_q <= `DCC_ZERO32;
        res_q <= `DCC_ZERO32;
        ecnt_q <= 10'h000;
        run_q <= 1'b0;
        arm_q <= 1'b0;
        scan_val_out <= `DCC_ZERO32;
      end else begin
        if (sos_in || latch_w) begin
          scan_val_out <= view_w;
        end
        // low read snapshots all 32 bits
        if (rd_lo_in) begin
          rd_val_out <= view_w;
        end
        case (mode_in)
          `DCC_M_CLRRD: begin
            // return old value, restart
            // An edge in the read cycle counts after the clear
            if (rd_lo_in) begin
              cnt_q <= up_w ? `DCC_ONE32 : `DCC_ZERO32;
            end else begin
              cnt_q <= cnt_d;
            end
          end
          `DCC_M_PERIOD: begin
            // gate pauses the tick count
            // Tick in a start cycle counts, so no tick is lost at a restart
            if (own_edge_w && !run_q) begin
              run_q <= 1'b1;
              cnt_q <= (tbt_q && gate_ok_w) ? `DCC_ONE32 : `DCC_ZERO32;
              ecnt_q <= 10'h000;
            end else if (own_edge_w) begin
              if (ecnt_q >= per_n_w - `DCC_X1) begin
                res_q <= dcc_clip(cnt_q, wide_in);
                cnt_q <= (tbt_q && gate_ok_w) ? `DCC_ONE32 : `DCC_ZERO32;
                ecnt_q <= 10'h000;
              end else begin
                ecnt_q <= ecnt_q + `DCC_X1;
                if (tbt_q && gate_ok_w) begin
                  cnt_q <= cnt_q + `DCC_ONE32;
                end
              end
            end else if (run_q && tbt_q && gate_ok_w) begin
              cnt_q <= cnt_q + `DCC_ONE32;
            end
          end
          `DCC_M_PULSE: begin
            if (own_fall_w) begin
              res_q <= dcc_clip(cnt_q, wide_in);
              cnt_q <= `DCC_ZERO32;
            end else if (deb_w && tbt_q && gate_ok_w) begin
              cnt_q <= cnt_q + `DCC_ONE32;
            end
          end
          `DCC_M_TIMING: begin
            // own edge to mapped edge
            // Start-cycle tick counts, like the period window
            if (own_edge_w) begin
              arm_q <= 1'b1;
              cnt_q <= tbt_q ? `DCC_ONE32 : `DCC_ZERO32;
            end else if (arm_q && map_edge_w) begin
              res_q <= dcc_clip(cnt_q, wide_in);
              arm_q <= 1'b0;
            end else if (arm_q && tbt_q) begin
              cnt_q <= cnt_q + `DCC_ONE32;
            end
          end
          default: begin
            // Totalize, rollover and stop-at-top
            // value kept across samples
            cnt_q <= cnt_d;
          end
        endcase
      end
    end
  end
endmodule

// ==== dcc_channel_props.sv ====
module dcc_chk #(
  parameter [31:0] DB_TICKS_PER_US = 32'h00000030
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire clk_en_in,
  input wire chan_in,
  input wire invert_in,
  input wire [1:0] db_mode_in,
  input wire wide_in,
  input wire [1:0] map_fn_in,
  input wire scan_start_in,
  input wire sos_in,
  input wire rd_lo_in,
  input wire deb_out,
  input wire [31:0] scan_val_out,
  input wire [31:0] rd_val_out,
  input wire [1:0] slots_out
);
  // Cycles of steady bypass; 3 covers the sync and filter flops
  reg [1:0] byp_q;
  always @(posedge clk_in) begin
    if (sys_rst_in || db_mode_in != 2'h0 || !clk_en_in || $changed(invert_in)) begin
      byp_q <= 2'h0;
    end else if (byp_q != 2'h3) begin
      byp_q <= byp_q + 2'h1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_reset_zero: assert property ($past(sys_rst_in) |-> scan_val_out == 32'h00000000
    && rd_val_out == 32'h00000000 && slots_out == 2'h1) else $error("Outputs not cleared");
  a_slots_width: assert property (!$past(sys_rst_in) && $past(clk_en_in) |->
    slots_out == ($past(wide_in) ? 2'h2 : 2'h1)) else $error("Slot count wrong");
  a_scan_clear: assert property ($past(scan_start_in) && $past(clk_en_in) &&
    !$past(sys_rst_in) |-> scan_val_out == 32'h00000000) else $error("Scan start kept value");
  a_scan_hold: assert property (!$past(sos_in) && !$past(scan_start_in) &&
    $past(map_fn_in) != 2'h3 && !$past(sys_rst_in) |-> $stable(scan_val_out))
    else $error("Scan value moved without latch");
  a_read_hold: assert property (!$past(rd_lo_in) && !$past(sys_rst_in) |->
    $stable(rd_val_out)) else $error("Read value moved without strobe");
  a_read_same: assert property ($past(rd_lo_in) && $past(sos_in) && $past(clk_en_in) &&
    !$past(scan_start_in) && !$past(sys_rst_in) |-> rd_val_out == scan_val_out)
    else $error("Read and scan snapshots differ");
  a_freeze_all: assert property (!$past(clk_en_in) && !$past(sys_rst_in) |->
    $stable(deb_out) && $stable(scan_val_out) && $stable(rd_val_out)) else $error("Not frozen");
  a_bypass_path: assert property (byp_q == 2'h3 |->
    deb_out == ($past(chan_in, 3) ^ $past(invert_in))) else $error("Bypass path wrong");
  c_read_scan: cover property (rd_lo_in && sos_in);
  c_after_rise: cover property (db_mode_in == 2'h1 && $rose(deb_out));
  c_before_rise: cover property (db_mode_in == 2'h2 && $rose(deb_out));
endmodule
bind dcc_channel dcc_chk #(.DB_TICKS_PER_US(DB_TICKS_PER_US)) i_chk (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in), .chan_in(chan_in), .invert_in(invert_in),
  .db_mode_in(db_mode_in), .wide_in(wide_in), .map_fn_in(map_fn_in),
  .scan_start_in(scan_start_in), .sos_in(sos_in), .rd_lo_in(rd_lo_in), .deb_out(deb_out),
  .scan_val_out(scan_val_out), .rd_val_out(rd_val_out), .slots_out(slots_out));

// ==== dcc_consts.vh ====
// How it works
// - Totalize counts each accepted edge upward
// - 16-bit uses one slot, 32-bit two
// - Count kept; cleared by scan start, or by a read in clear-on-read
// - Rollover wraps past maximum to zero
// - Clear-on-read returns old count, restarts zero
// - Stop-at-top saturates at all ones
// - Width sets stop-at-top, measurement clipping and slots
// - Period over 1/10/100/1000 input periods
// - Four timebases from 48 MHz system tick
// - Mapped channel can gate period measurement
// - Pulse width counts ticks while active
// - Timing counts from own to mapped edge
// - Sixteen debounce intervals, 500 ns-25.5 ms
// - Inverter selects active edge polarity
// - Bypass feeds inverter output straight through
// - After-stable changes once level held interval
// - After-stable rejects never-stable disturbances
// - Before-stable follows edge, then holds
// - Before-stable edge needs prior stable interval
// - Low-half read snapshots full 32 bits
// - Mapped input gates, decrements or latches
// - Start-of-scan latches value; acquisition starts zero
`ifndef DCC_CONSTS_VH
`define DCC_CONSTS_VH
// Counter modes
`define DCC_M_TOTAL 3'h0
`define DCC_M_CLRRD 3'h1
`define DCC_M_ROLL 3'h2
`define DCC_M_STOP 3'h3
`define DCC_M_PERIOD 3'h4
`define DCC_M_PULSE 3'h5
`define DCC_M_TIMING 3'h6
// Debounce modes
`define DCC_DB_BYPASS 2'h0
`define DCC_DB_AFTER 2'h1
`define DCC_DB_BEFORE 2'h2
// Mapped channel functions
`define DCC_MAP_NONE 2'h0
`define DCC_MAP_GATE 2'h1
`define DCC_MAP_DEC 2'h2
`define DCC_MAP_LATCH 2'h3
// Tops of count
`define DCC_TOP32 32'hFFFFFFFF
`define DCC_TOP16 16'hFFFF
`define DCC_ZERO32 32'h00000000
`define DCC_ONE32 32'h00000001
// Sample slots per value
`define DCC_SLOTS16 2'h1
`define DCC_SLOTS32 2'h2
// 48 MHz tick from 100 MHz clock, by phase accumulator
`define DCC_SYS_MHZ 8'h30
`define DCC_CLK_MHZ 8'h64
// Multipliers for timebase and period count
`define DCC_X1 10'h001
`define DCC_X10 10'h00A
`define DCC_X100 10'h064
`define DCC_X1000 10'h3E8
// Debounce intervals in ns
`define DCC_DB_NS0 32'h000001F4
`define DCC_DB_NS1 32'h000003E8
`define DCC_DB_NS2 32'h000007D0
`define DCC_DB_NS3 32'h00001388
`define DCC_DB_NS4 32'h00002710
`define DCC_DB_NS5 32'h00004E20
`define DCC_DB_NS6 32'h0000C350
`define DCC_DB_NS7 32'h000186A0
`define DCC_DB_NS8 32'h00030D40
`define DCC_DB_NS9 32'h0007A120
`define DCC_DB_NS10 32'h000F4240
`define DCC_DB_NS11 32'h001E8480
`define DCC_DB_NS12 32'h004C4B40
`define DCC_DB_NS13 32'h00989680
`define DCC_DB_NS14 32'h01312D00
`define DCC_DB_NS15 32'h01851960
`define DCC_NS_PER_US 32'h000003E8
`endif

// ==== dcc_debounce.v ====
`include "dcc_consts.vh"
module dcc_debounce #(
  parameter [31:0] TICKS_PER_US = 32'h00000030
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire clk_en_in,
  input wire lvl_in,
  input wire tick_in,
  input wire [1:0] mode_in,
  input wire [3:0] sel_in,
  output reg lvl_out
);
  reg [31:0] ns_w; // Selected interval in ns
  wire [31:0] lim_w; // Interval in 48 MHz ticks
  reg [31:0] stab_q; // Ticks since last level change
  reg prev_q; // Previous input sample
  wire chg_w;
  wire stable_w;

  // Interval table
  // sixteen interval choices
  always @* begin
    case (sel_in)
      4'h0: ns_w = `DCC_DB_NS0;
      4'h1: ns_w = `DCC_DB_NS1;
      4'h2: ns_w = `DCC_DB_NS2;
      4'h3: ns_w = `DCC_DB_NS3;
      4'h4: ns_w = `DCC_DB_NS4;
      4'h5: ns_w = `DCC_DB_NS5;
      4'h6: ns_w = `DCC_DB_NS6;
      4'h7: ns_w = `DCC_DB_NS7;
      4'h8: ns_w = `DCC_DB_NS8;
      4'h9: ns_w = `DCC_DB_NS9;
      4'hA: ns_w = `DCC_DB_NS10;
      4'hB: ns_w = `DCC_DB_NS11;
      4'hC: ns_w = `DCC_DB_NS12;
      4'hD: ns_w = `DCC_DB_NS13;
      4'hE: ns_w = `DCC_DB_NS14;
      default: ns_w = `DCC_DB_NS15;
    endcase
  end

  // Largest product stays below 2^31 at 48 ticks per us
  assign lim_w = (ns_w * TICKS_PER_US) / `DCC_NS_PER_US;
  assign chg_w = lvl_in ^ prev_q;
  // Stable means the level before this sample held a full interval
  assign stable_w = (stab_q >= lim_w);

  // Stability counter and filter output
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      stab_q <= `DCC_ZERO32;
      prev_q <= 1'b0;
      lvl_out <= 1'b0;
    end else if (clk_en_in) begin
      prev_q <= lvl_in;
      if (chg_w) begin
        stab_q <= `DCC_ZERO32;
      end else if (tick_in && !stable_w) begin
        stab_q <= stab_q + `DCC_ONE32;
      end
      case (mode_in)
        `DCC_DB_BYPASS: lvl_out <= lvl_in;
        `DCC_DB_AFTER: begin
          if (!chg_w && stable_w) begin
            lvl_out <= lvl_in;
          end
        end
        `DCC_DB_BEFORE: begin
          if (chg_w) begin
            if (stable_w) begin
              lvl_out <= lvl_in;
            end
          end else if (stable_w) begin
            lvl_out <= lvl_in;
          end
        end
        default: lvl_out <= lvl_in;
      endcase
    end
  end
endmodule

// ==== dcc_src.sv ====
module dcc_src (
  input wire clk_in,
  output logic lvl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial lvl_out = 1'b0;
  // Clean pulse; call at a falling edge, slow or fast by hi and lo
  task automatic pulse(input int hi, input int lo);
    lvl_out = 1'b1;
    repeat (hi) @(negedge clk_in);
    lvl_out = 1'b0;
    repeat (lo) @(negedge clk_in);
  endtask
  // Contact bounce: one-cycle glitches, then rests low
  task automatic bounce(input int n);
    repeat (n) begin
      lvl_out = ~lvl_out;
      @(negedge clk_in);
    end
    lvl_out = 1'b0;
  endtask
endmodule

// ==== test_debounced_counter_channel.sv ====
`include "dcc_consts.vh"
module test_debounced_counter_channel;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [2:0] m; logic w; logic [1:0] f; logic [1:0] x;
    int dec; int up; int hi; logic [31:0] e1; logic [31:0] e2;} dcc_row_t;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1, invert_in = 1'b0, wide_in = 1'b0;
  logic [1:0] db_mode_in = 2'h0, per_mult_in = 2'h0, tb_sel_in = 2'h0, map_fn_in = 2'h0;
  logic [3:0] db_sel_in = 4'hF;
  logic [2:0] mode_in = 3'h0;
  logic [1:0] map_sel = 2'h1;
  logic map_lvl = 1'b0, scan_start_in = 1'b0, sos_in = 1'b0, rd_lo_in = 1'b0, deb_q = 1'b0;
  wire chan_in, deb_out;
  wire [31:0] scan_val_out, rd_val_out;
  wire [1:0] slots_out;
  int fail_count = 0, num_checks = 0, cycles = 0, rises = 0;
  // Counting rows use fast pulses; measuring rows use 100-cycle periods
  dcc_row_t rows [9] = '{
    '{`DCC_M_TOTAL, 1, `DCC_MAP_NONE, 0, 0, 5, 3, 32'h00000005, 32'h00000005},
    '{`DCC_M_TOTAL, 0, `DCC_MAP_DEC, 0, 1, 1, 3, 32'h00000000, 32'h00000000},
    '{`DCC_M_ROLL, 1, `DCC_MAP_DEC, 0, 1, 2, 3, 32'h00000001, 32'h00000001},
    '{`DCC_M_STOP, 1, `DCC_MAP_DEC, 0, 1, 3, 3, 32'hFFFFFFFF, 32'hFFFFFFFF},
    '{`DCC_M_CLRRD, 0, `DCC_MAP_NONE, 0, 0, 3, 3, 32'h00000003, 32'h00000000},
    '{`DCC_M_TOTAL, 1, `DCC_MAP_GATE, 0, 0, 3, 3, 32'h00000000, 32'h00000000},
    '{`DCC_M_PERIOD, 1, `DCC_MAP_NONE, 0, 0, 2, 50, 32'h00000030, 32'h00000030},
    '{`DCC_M_PERIOD, 1, `DCC_MAP_NONE, 1, 0, 11, 50, 32'h000001E0, 32'h000001E0},
    '{`DCC_M_PULSE, 1, `DCC_MAP_NONE, 0, 0, 1, 50, 32'h00000018, 32'h00000018}};
  dcc_src i_src (.clk_in(clk_in), .lvl_out(chan_in));
  // Small scale so 500 ns is one tick
  dcc_channel #(.DB_TICKS_PER_US(32'h00000002)) i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .chan_in(chan_in), .invert_in(invert_in), .db_mode_in(db_mode_in),
    .db_sel_in(db_sel_in), .mode_in(mode_in), .wide_in(wide_in), .per_mult_in(per_mult_in),
    .tb_sel_in(tb_sel_in), .map_in({map_lvl, ~map_lvl, map_lvl, deb_out}), .map_sel_in(map_sel),
    .map_fn_in(map_fn_in), .scan_start_in(scan_start_in), .sos_in(sos_in), .rd_lo_in(rd_lo_in),
    .deb_out(deb_out), .scan_val_out(scan_val_out), .rd_val_out(rd_val_out),
    .slots_out(slots_out));
  always #5 clk_in = ~clk_in;
  // Hang guard and count of filtered rising edges
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    deb_q <= deb_out;
    if (deb_out === 1'b1 && deb_q === 1'b0) rises <= rises + 1;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle strobes, released a full cycle before return
  task automatic strobe(input logic st, input logic so, input logic rd);
    scan_start_in = st;
    sos_in = so;
    rd_lo_in = rd;
    @(negedge clk_in);
    {scan_start_in, sos_in, rd_lo_in} = 3'h0;
    @(negedge clk_in);
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk(scan_val_out | rd_val_out, 32'h0);
    chk({30'h0, slots_out}, 32'h1);
    foreach (rows[i]) begin
      {mode_in, wide_in, map_fn_in, per_mult_in} = {rows[i].m, rows[i].w, rows[i].f, rows[i].x};
      strobe(1'b1, 1'b0, 1'b0);
      repeat (rows[i].dec) begin
        map_lvl = 1'b1;
        repeat (3) @(negedge clk_in);
        map_lvl = 1'b0;
        repeat (3) @(negedge clk_in);
      end
      repeat (rows[i].up) i_src.pulse(rows[i].hi, rows[i].hi);
      repeat (6) @(negedge clk_in);
      strobe(1'b0, 1'b1, 1'b1);
      chk(scan_val_out, rows[i].e1);
      chk({30'h0, slots_out}, rows[i].w ? 32'h2 : 32'h1);
      strobe(1'b0, 1'b0, 1'b1);
      chk(rd_val_out, rows[i].e2);
    end
    // Own edge to mapped edge over 250 cycles: 12 ticks of the 10-tick base
    {mode_in, map_fn_in, tb_sel_in} = {`DCC_M_TIMING, `DCC_MAP_NONE, 2'h1};
    strobe(1'b1, 1'b0, 1'b0);
    i_src.pulse(3, 250);
    map_lvl = 1'b1;
    repeat (3) @(negedge clk_in);
    map_lvl = 1'b0;
    strobe(1'b0, 1'b1, 1'b0);
    chk(scan_val_out, 32'h0000000C);
    // Index 2 sees the inverted level, so the gate is open
    {mode_in, map_fn_in, map_sel} = {`DCC_M_TOTAL, `DCC_MAP_GATE, 2'h2};
    strobe(1'b1, 1'b0, 1'b0);
    repeat (3) i_src.pulse(3, 3);
    map_sel = 2'h1;
    repeat (2) @(negedge clk_in);
    // Mapped rising edge latches the count without a scan strobe
    map_fn_in = `DCC_MAP_LATCH;
    map_lvl = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(scan_val_out, 32'h00000003);
    map_lvl = 1'b0;
    // Reset in mid-run clears both snapshots
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk(scan_val_out | rd_val_out, 32'h0);
    chk({30'h0, slots_out}, 32'h1);
    // Frozen clock enable ignores pulses
    {mode_in, map_fn_in} = {`DCC_M_TOTAL, `DCC_MAP_NONE};
    strobe(1'b1, 1'b0, 1'b0);
    clk_en_in = 1'b0;
    repeat (2) i_src.pulse(3, 3);
    clk_en_in = 1'b1;
    repeat (6) @(negedge clk_in);
    strobe(1'b0, 1'b1, 1'b0);
    chk(scan_val_out, 32'h0);
    invert_in = 1'b1;
    repeat (5) @(negedge clk_in);
    chk({31'h0, deb_out}, 32'h1);
    invert_in = 1'b0;
    repeat (5) @(negedge clk_in);
    rises = 0;
    i_src.bounce(8);
    repeat (6) @(negedge clk_in);
    chk(rises, 4);
    // After-stable, 10 us interval: about 42 cycles
    {db_mode_in, db_sel_in} = {`DCC_DB_AFTER, 4'h4};
    repeat (100) @(negedge clk_in);
    rises = 0;
    i_src.bounce(20);
    i_src.pulse(30, 100);
    chk(rises, 0);
    i_src.pulse(60, 100);
    chk(rises, 1);
    db_mode_in = `DCC_DB_BEFORE;
    repeat (100) @(negedge clk_in);
    rises = 0;
    i_src.bounce(1);
    repeat (4) @(negedge clk_in);
    chk({31'h0, deb_out}, 32'h1);
    i_src.bounce(20);
    i_src.pulse(3, 100);
    chk(rises, 1);
    i_src.pulse(3, 100);
    chk(rises, 2);
    finish_test();
  end
endmodule
